// ==== dfc_top.sv ====
// Purpose: Decimation filter configuration registers and output-word / periodic-idle sequencer.
// Assumes: Register port and modulator sample enable come from logic on clk.
// Notes:   A write to the control or cubic rate registers restarts the current output word; an idle ratio write does not.
`timescale 1ns/10ps
`include "dfc_cfg.svh"

module dfc_top (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    // Modulator side
    input  wire logic                      mod_sample_en,
    input  wire logic                      periodic_en,
    // Decimation datapath control
    output dfc_pkg::dfc_filter_t           filter_path,
    output logic      [`DFC_RATIO_W-1:0]   decim_ratio,
    output logic                           trunc16,
    output logic                           word_strobe,
    output logic                           standby
);
    import dfc_pkg::*;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [2:0]  filt_type_r;
    logic [2:0]  ratio_sel_r;
    logic [4:0]  cubic_high_r;
    logic [7:0]  cubic_low_r;
    logic [7:0]  idle_ratio_r;
    logic [7:0]  rdata_r;

    localparam logic [7:0] rst_ctrl_val = `DFC_RST_FILTER_CTRL;
    localparam logic [7:0] rst_high_val = `DFC_RST_CUBIC_HIGH;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    wire       hit_ctrl  = reg_addr == `DFC_OFS_FILTER_CTRL;
    wire       hit_high  = reg_addr == `DFC_OFS_CUBIC_HIGH;
    wire       hit_low   = reg_addr == `DFC_OFS_CUBIC_LOW;
    wire       hit_idle  = reg_addr == `DFC_OFS_IDLE_RATIO;
    wire       wr_ctrl   = reg_wr && hit_ctrl;
    wire       wr_high   = reg_wr && hit_high;
    wire       wr_low    = reg_wr && hit_low;
    wire       wr_idle   = reg_wr && hit_idle;
    wire [2:0] wtype     = reg_wdata[`DFC_FILT_TYPE_HI:`DFC_FILT_TYPE_LO];
    // Unused filter codes are not taken so the path always stays defined.
    wire       type_ok   = wtype <= DFC_FILT_FIR;
    // A write that changes the ratio or path restarts the current output word.
    wire       cfg_write = wr_ctrl || wr_high || wr_low;

    wire [7:0] ctrl_rd = {1'b0, filt_type_r, 1'b0, ratio_sel_r};
    wire [7:0] rd_mux  = hit_ctrl ? ctrl_rd :
                         hit_high ? {3'h0, cubic_high_r} :
                         hit_low  ? cubic_low_r :
                         hit_idle ? idle_ratio_r : 8'h00;

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filt_type_r <= rst_ctrl_val[`DFC_FILT_TYPE_HI:`DFC_FILT_TYPE_LO];
        end else if (wr_ctrl && type_ok) begin
            filt_type_r <= wtype;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ratio_sel_r <= rst_ctrl_val[`DFC_RATIO_SEL_HI:`DFC_RATIO_SEL_LO];
        end else if (wr_ctrl) begin
            ratio_sel_r <= reg_wdata[`DFC_RATIO_SEL_HI:`DFC_RATIO_SEL_LO];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cubic_high_r <= rst_high_val[`DFC_CUBIC_HIGH_HI:0];
        end else if (wr_high) begin
            cubic_high_r <= reg_wdata[`DFC_CUBIC_HIGH_HI:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cubic_low_r <= `DFC_RST_CUBIC_LOW;
        end else if (wr_low) begin
            cubic_low_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_ratio_r <= `DFC_RST_IDLE_RATIO;
        end else if (wr_idle) begin
            idle_ratio_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Ratio decode
    // ------------------------------------------------------------------------
    dfc_cfg_if cfg_bus ();

    assign cfg_bus.filter_code = filt_type_r;
    assign cfg_bus.ratio_sel   = ratio_sel_r;
    assign cfg_bus.cubic_val   = {cubic_high_r, cubic_low_r};

    dfc_ratio_dec u_dec (
        .cfg (cfg_bus.dec)
    );

    // ------------------------------------------------------------------------
    // Output word and periodic idle sequencer
    // ------------------------------------------------------------------------
    logic [`DFC_RATIO_W-1:0] samp_cnt_r;
    logic [`DFC_RATIO_W-1:0] samp_cnt_nxt;
    logic [9:0]              idle_cnt_r;
    logic [9:0]              idle_cnt_nxt;
    dfc_state_t              state_r;
    dfc_state_t              state_nxt;
    logic                    strobe_nxt;

    wire       period_end = mod_sample_en && (samp_cnt_r >= cfg_bus.ratio - `DFC_RATIO_W'(1));
    // Idle length in output periods: (gap + 1) * 2, at most 512.
    wire [9:0] idle_len   = {1'b0, idle_ratio_r, 1'b0} + 10'h002;

    always_comb begin
        samp_cnt_nxt = samp_cnt_r;
        idle_cnt_nxt = idle_cnt_r;
        state_nxt    = state_r;
        strobe_nxt   = 1'b0;
        if (cfg_write) begin
            samp_cnt_nxt = '0;
            idle_cnt_nxt = 10'h000;
            state_nxt    = DFC_ST_CONVERT;
        end else if (mod_sample_en) begin
            samp_cnt_nxt = period_end ? '0 : samp_cnt_r + `DFC_RATIO_W'(1);
            case (state_r)
                DFC_ST_CONVERT: begin
                    if (period_end) begin
                        strobe_nxt = 1'b1;
                        if (periodic_en) begin
                            state_nxt    = DFC_ST_IDLE;
                            idle_cnt_nxt = 10'h000;
                        end
                    end
                end
                DFC_ST_IDLE: begin
                    if (!periodic_en) begin
                        state_nxt = DFC_ST_CONVERT;
                    end else if (period_end) begin
                        if (idle_cnt_r == idle_len - 10'h001) begin
                            state_nxt = DFC_ST_CONVERT;
                        end else begin
                            idle_cnt_nxt = idle_cnt_r + 10'h001;
                        end
                    end
                end
                default: begin
                    state_nxt = DFC_ST_CONVERT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samp_cnt_r <= '0;
            idle_cnt_r <= 10'h000;
            state_r    <= DFC_ST_CONVERT;
        end else begin
            samp_cnt_r <= samp_cnt_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            state_r    <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filter_path <= DFC_FILT_SINC5;
            decim_ratio <= '0;
            trunc16     <= 1'b0;
            word_strobe <= 1'b0;
            standby     <= 1'b0;
        end else begin
            filter_path <= cfg_bus.path;
            decim_ratio <= cfg_bus.ratio;
            trunc16     <= cfg_bus.trunc16;
            word_strobe <= strobe_nxt;
            standby     <= (state_nxt == DFC_ST_IDLE);
        end
    end

    assign reg_rdata = rdata_r;
endmodule

// ==== dfc_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts of the decimation filter configuration.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes:   Definitions only.
`ifndef DFC_CFG_SVH
`define DFC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DFC_OFS_FILTER_CTRL    8'h19
`define DFC_OFS_CUBIC_HIGH     8'h1A
`define DFC_OFS_CUBIC_LOW      8'h1B
`define DFC_OFS_IDLE_RATIO     8'h1C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define DFC_FILT_TYPE_HI       6
`define DFC_FILT_TYPE_LO       4
`define DFC_RATIO_SEL_HI       2
`define DFC_RATIO_SEL_LO       0
`define DFC_CUBIC_HIGH_HI      4
`define DFC_RST_FILTER_CTRL    8'h00
`define DFC_RST_CUBIC_HIGH     8'h00
`define DFC_RST_CUBIC_LOW      8'h00
`define DFC_RST_IDLE_RATIO     8'h00

// ----------------------------------------------------------------------------
// Ratios and counts
// ----------------------------------------------------------------------------
`define DFC_RATIO_BASE_SHIFT   5
`define DFC_RATIO_SEL_MAX      3'h5
`define DFC_RATIO_FIXED_8      19'h00008
`define DFC_RATIO_FIXED_16     19'h00010
`define DFC_RATIO_W            19
`define DFC_CUBIC_W            13

`endif

// ==== dfc_pkg.sv ====
// Purpose: Types shared by the decimation filter configuration modules.
// Assumes: Nothing beyond the configuration header.
// Notes:   Codes 101 to 111 of the filter type have no path.
package dfc_pkg;

    typedef enum logic [2:0] {
        DFC_FILT_SINC5     = 3'h0,
        DFC_FILT_SINC5_X8  = 3'h1,
        DFC_FILT_SINC5_X16 = 3'h2,
        DFC_FILT_SINC3     = 3'h3,
        DFC_FILT_FIR       = 3'h4
    } dfc_filter_t;

    typedef enum logic [0:0] {
        DFC_ST_CONVERT = 1'h0,
        DFC_ST_IDLE    = 1'h1
    } dfc_state_t;

endpackage

// ==== dfc_cfg_if.sv ====
// Purpose: Carries register settings to the ratio decoder and the decoded path back.
// Assumes: Single clock domain, purely combinational decoder.
// Notes:   None.
`timescale 1ns/10ps
`include "dfc_cfg.svh"

interface dfc_cfg_if;
    import dfc_pkg::*;
    logic [2:0]                filter_code;
    logic [2:0]                ratio_sel;
    logic [`DFC_CUBIC_W-1:0]   cubic_val;
    dfc_filter_t               path;
    logic [`DFC_RATIO_W-1:0]   ratio;
    logic                      trunc16;

    modport ctrl (output filter_code, output ratio_sel, output cubic_val,
                  input path, input ratio, input trunc16);
    modport dec  (input filter_code, input ratio_sel, input cubic_val,
                  output path, output ratio, output trunc16);
endinterface

// ==== dfc_ratio_dec.sv ====
// Purpose: Decodes filter type, ratio select and cubic rate value into a path and a decimation ratio.
// Assumes: Filter code is always one of 000 to 100.
// Notes:   Combinational; the top registers the results.
`timescale 1ns/10ps
`include "dfc_cfg.svh"

module dfc_ratio_dec (
    // Settings in, decoded path out
    dfc_cfg_if.dec cfg
);
    import dfc_pkg::*;

    wire [2:0]              sel_clip;
    wire [`DFC_RATIO_W-1:0] sel_ratio;
    wire [13:0]             cubic_plus1;
    wire [`DFC_RATIO_W-1:0] cubic_ratio;

    assign sel_clip    = (cfg.ratio_sel > `DFC_RATIO_SEL_MAX) ? `DFC_RATIO_SEL_MAX : cfg.ratio_sel;
    assign sel_ratio   = `DFC_RATIO_W'(32'd1 << (`DFC_RATIO_BASE_SHIFT + 32'(sel_clip)));
    assign cubic_plus1 = {1'b0, cfg.cubic_val} + 14'h0001;
    assign cubic_ratio = {cubic_plus1, 5'h00};

    assign cfg.path    = dfc_filter_t'(cfg.filter_code);
    assign cfg.trunc16 = (cfg.filter_code == DFC_FILT_SINC5_X8);
    assign cfg.ratio   = (cfg.filter_code == DFC_FILT_SINC5_X8)  ? `DFC_RATIO_FIXED_8 :
                         (cfg.filter_code == DFC_FILT_SINC5_X16) ? `DFC_RATIO_FIXED_16 :
                         (cfg.filter_code == DFC_FILT_SINC3)     ? cubic_ratio :
                         sel_ratio;
endmodule

// ==== dfc_monitor.sv ====
// Purpose: Concurrent checks on the decimation filter configuration ports.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to dfc_top after the module.
`timescale 1ns/10ps
`include "dfc_cfg.svh"

module dfc_monitor
    import dfc_pkg::*;
(
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rstn,
    // Register port
    input wire logic [7:0]              reg_addr,
    input wire logic                    reg_wr,
    input wire logic [7:0]              reg_wdata,
    input wire logic                    reg_rd,
    input wire logic [7:0]              reg_rdata,
    // Datapath control
    input wire dfc_pkg::dfc_filter_t    filter_path,
    input wire logic [`DFC_RATIO_W-1:0] decim_ratio,
    input wire logic                    trunc16,
    input wire logic                    word_strobe,
    input wire logic                    standby
);
    wire         wr19  = reg_wr && reg_addr == 8'h19;
    wire  [2:0]  code  = reg_wdata[6:4];
    wire  [18:0] sel_r = (reg_wdata[2:0] > 3'h4) ? 19'h00400 : 19'h00020 << reg_wdata[2:0];
    logic [12:0] cubic_r;

    // Shadow of the cubic rate value, so its ratio can be checked at the ports.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) cubic_r <= 13'h0000;
        else if (reg_wr && reg_addr == 8'h1A) cubic_r <= {reg_wdata[4:0], cubic_r[7:0]};
        else if (reg_wr && reg_addr == 8'h1B) cubic_r <= {cubic_r[12:8], reg_wdata};
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Path, ratio and truncation outputs follow a configuration write by two edges.
    a_sinc5_ratio: assert property (wr19 && code == 3'h0 |=> ##1 filter_path == DFC_FILT_SINC5
        && decim_ratio == $past(sel_r, 2) && !trunc16) else $error("sinc5 path or ratio wrong");
    a_fir_ratio: assert property (wr19 && code == 3'h4 |=> ##1 filter_path == DFC_FILT_FIR
        && decim_ratio == $past(sel_r, 2)) else $error("fir path or ratio wrong");
    a_fixed_x8: assert property (wr19 && code == 3'h1 |=> ##1 filter_path == DFC_FILT_SINC5_X8
        && decim_ratio == 19'h00008 && trunc16) else $error("x8 path wrong");
    a_fixed_x16: assert property (wr19 && code == 3'h2 |=> ##1 filter_path == DFC_FILT_SINC5_X16
        && decim_ratio == 19'h00010 && !trunc16) else $error("x16 path wrong");
    a_unused_kept: assert property (wr19 && code > 3'h4 |=> ##1 $stable(filter_path))
        else $error("unused filter code changed the path");
    a_cubic_ratio: assert property (filter_path == DFC_FILT_SINC3
        |-> decim_ratio == (19'($past(cubic_r)) + 19'h00001) << 5) else $error("cubic ratio wrong");
    a_ctrl_reserved: assert property (reg_rd && reg_addr == 8'h19 |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("reserved control bits read nonzero");
    a_high_reserved: assert property (reg_rd && reg_addr == 8'h1A |=> reg_rdata[7:5] == 3'h0)
        else $error("reserved high bits read nonzero");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h19 || reg_addr > 8'h1C) |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
    a_standby_start: assert property ($rose(standby) |-> word_strobe)
        else $error("standby rose without a word");
    a_idle_quiet: assert property (standby && $past(standby) |-> !word_strobe)
        else $error("word during idle");
endmodule

bind dfc_top dfc_monitor i_dfc_monitor (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filter_path(filter_path),
    .decim_ratio(decim_ratio), .trunc16(trunc16), .word_strobe(word_strobe), .standby(standby));

// ==== dfc_top_tb_top.sv ====
// Purpose: Self-checking bench for the decimation filter configuration.
// Assumes: Inputs change at rising edges, outputs sampled at falling edges.
// Notes:   Register cases are table rows; sequencer and reset are hand tests.
`timescale 1ns/10ps

module dfc_top_tb_top;
    import dfc_pkg::*;
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic [2:0]  path;
        logic [18:0] ratio;
        logic        trunc;
    } dfc_row_t;
    logic        clk, rstn, reg_wr, reg_rd, mod_sample_en, periodic_en, trunc16, word_strobe, standby;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [18:0] decim_ratio;
    dfc_filter_t filter_path;
    int          n_errors, cmp_count, cyc, g, s;
    dfc_row_t    rows [22] = '{
        '{8'h19, 8'h00, 8'h00, 3'h0, 19'h00020, 1'b0}, '{8'h19, 8'h01, 8'h01, 3'h0, 19'h00040, 1'b0},
        '{8'h19, 8'h02, 8'h02, 3'h0, 19'h00080, 1'b0}, '{8'h19, 8'h03, 8'h03, 3'h0, 19'h00100, 1'b0},
        '{8'h19, 8'h0C, 8'h04, 3'h0, 19'h00200, 1'b0}, '{8'h19, 8'h05, 8'h05, 3'h0, 19'h00400, 1'b0},
        '{8'h19, 8'h06, 8'h06, 3'h0, 19'h00400, 1'b0}, '{8'h19, 8'h87, 8'h07, 3'h0, 19'h00400, 1'b0},
        '{8'h19, 8'h13, 8'h13, 3'h1, 19'h00008, 1'b1}, '{8'h19, 8'h27, 8'h27, 3'h2, 19'h00010, 1'b0},
        '{8'h19, 8'h41, 8'h41, 3'h4, 19'h00040, 1'b0}, '{8'h19, 8'hD5, 8'h45, 3'h4, 19'h00400, 1'b0},
        '{8'h19, 8'h63, 8'h43, 3'h4, 19'h00100, 1'b0}, '{8'h19, 8'h72, 8'h42, 3'h4, 19'h00080, 1'b0},
        '{8'h1A, 8'hFF, 8'h1F, 3'h4, 19'h00080, 1'b0}, '{8'h1B, 8'h02, 8'h02, 3'h4, 19'h00080, 1'b0},
        '{8'h19, 8'h30, 8'h30, 3'h3, 19'h3E060, 1'b0}, '{8'h1A, 8'h00, 8'h00, 3'h3, 19'h00060, 1'b0},
        '{8'h1B, 8'h00, 8'h00, 3'h3, 19'h00020, 1'b0}, '{8'h1C, 8'hA5, 8'hA5, 3'h3, 19'h00020, 1'b0},
        '{8'h1D, 8'h55, 8'h00, 3'h3, 19'h00020, 1'b0}, '{8'h18, 8'h55, 8'h00, 3'h3, 19'h00020, 1'b0}};

    dfc_top i_dfc_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_sample_en(mod_sample_en), .periodic_en(periodic_en),
        .filter_path(filter_path), .decim_ratio(decim_ratio), .trunc16(trunc16), .word_strobe(word_strobe),
        .standby(standby));

    task automatic end_of_test;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [18:0] exp, input logic [18:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", 19'(e), 19'(reg_rdata));
    endtask

    // Measures from one word to the next: cycles between, and cycles spent idle.
    task automatic meas(output int gap, output int sb);
        int k;
        k = 0;
        @(negedge clk);
        while (word_strobe !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        gap = 0;
        sb  = int'(standby === 1'b1);
        do begin
            @(negedge clk);
            gap++;
            if (standby === 1'b1 && word_strobe !== 1'b1) sb++;
        end while (word_strobe !== 1'b1 && gap < 2000);
        if (k >= 2000 || gap >= 2000) n_errors++;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        {rstn, reg_wr, reg_rd, mod_sample_en, periodic_en, reg_addr, reg_wdata} = '0;
        {n_errors, cmp_count, cyc} = '0;
        repeat (16) @(posedge clk);
        rstn          <= 1'b1;
        mod_sample_en <= 1'b1;
        for (int a = 8'h19; a <= 8'h1C; a++) rd(8'(a), 8'h00);
        chk("decim_ratio", 19'h00020, decim_ratio);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
            chk("filter_path", 19'(rows[i].path), 19'(filter_path));
            chk("decim_ratio", rows[i].ratio, decim_ratio);
            chk("trunc16", 19'(rows[i].trunc), 19'(trunc16));
        end
        // Idle value 1 gives 4 idle words of 32 samples, then one word of 32.
        wr(8'h1C, 8'h01);
        // The bench plays a host in the median or low power setting, so periodic mode is allowed.
        periodic_en <= 1'b1;
        meas(g, s);
        meas(g, s);
        chk("word_gap", 19'd160, 19'(g));
        chk("idle_len", 19'd128, 19'(s));
        @(posedge clk);
        periodic_en <= 1'b0;
        meas(g, s);
        meas(g, s);
        chk("word_gap", 19'd32, 19'(g));
        @(posedge clk);
        periodic_en <= 1'b1;
        meas(g, s);
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk("standby", 19'h0, 19'(standby));
        chk("decim_ratio", 19'h0, decim_ratio);
        @(posedge clk);
        rstn        <= 1'b1;
        periodic_en <= 1'b0;
        rd(8'h1C, 8'h00);
        rd(8'h1B, 8'h00);
        chk("decim_ratio", 19'h00020, decim_ratio);
        end_of_test();
    end
endmodule
